// ### hdl/pdr_ctrl.sv
module pdr_ctrl import pdr_pkg::*; #(
	parameter int N_EXT = 10
) (
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core side
	input wire logic op_valid,
	input wire logic [7:0] op_code,
	input wire logic [15:0] next_pc,
	input wire logic return_from_interrupt,
	input wire logic [7:0] option_byte,
	// Supply and reset sources
	input wire logic reset_pin_n,
	input wire logic vdd_above_detect,
	input wire logic supply_below_fraction,
	input wire logic watchdog_overflow,
	input wire logic abnormal_state,
	// Wake sources
	input wire logic [N_EXT-1:0] external_interrupt_lines,
	input wire logic internal_irq,
	input wire logic [7:0] wake_port_zero,
	input wire logic [3:0] wake_port_two_upper,
	// Outputs to the rest of the chip
	output logic sys_reset,
	output logic ctrl_regs_reset,
	output logic data_undefined,
	output logic osc_run,
	output logic core_clk_en,
	output logic periph_clk_en,
	output logic active_clk_en,
	output logic port_dir_hold,
	output logic [1:0] clk_div_sel,
	output logic irq_service,
	output logic pc_load,
	output logic [15:0] pc_value
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pdr_mode_t mode_q, mode_d; // Power mode
	logic [7:0] stop_q; // stop_control_reg
	logic [7:0] clkc_q; // clock_control_reg
	logic [10:0] imr_q; // Bit 10 gates internal irq
	logic [2:0] cause_q; // Last reset cause
	logic [4:0] rcnt_q; // Reset pulse counter
	logic [15:0] ret_pc_q; // Idle resume address
	logic pin_q; // Last reset pin level
	logic vdd_q; // Last detector level
	logic [11:0] port_q; // Last wake port levels
	logic por_seen_q; // Supply fell to fraction in stop
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic undef_q;
	logic pc_load_q;
	logic [15:0] pc_q;
	logic irq_svc_q;
	logic [2:0] cause_d; // Merged cause this cycle
	logic opt; // Stop detector option bit
	logic wr_hit; // Write taken this edge
	logic in_stop;
	logic pin_rise;
	logic vdd_rise;
	logic vdd_fall;
	logic lvd_on;
	logic [11:0] port_now;
	logic sed_edge;
	logic ext_wake;
	logic idle_wake;
	logic go_idle;
	logic go_stop;
	logic rst_req;
	logic stop_release;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Register index check, used only for pslverr; the read mux decodes paddr itself
	function automatic logic is_mapped(input logic [7:0] a);
		return a == PDR_OFS_STOP || a == PDR_OFS_CLK ||
			a == PDR_OFS_IMR || a == PDR_OFS_STAT;
	endfunction

	// ----------------------------------------------------------------
	// Source detection
	// ----------------------------------------------------------------
	assign opt = option_byte[PDR_OPT_BIT];
	assign in_stop = mode_q == PDR_STOP;
	// Detector is off in stop when option is 0, to save current
	assign lvd_on = opt || !in_stop;
	assign pin_rise = reset_pin_n && !pin_q;
	assign vdd_rise = vdd_above_detect && !vdd_q;
	assign vdd_fall = !vdd_above_detect && vdd_q;
	assign port_now = {wake_port_two_upper, wake_port_zero};
	// Any falling edge on port 0 or port 2 upper nibble
	assign sed_edge = |(port_q & ~port_now);
	assign ext_wake = |(external_interrupt_lines & imr_q[N_EXT-1:0]);
	// Idle accepts external and internal interrupts alike
	assign idle_wake = ext_wake || (internal_irq && imr_q[10]);
	assign go_idle = op_valid && op_code == PDR_OP_IDLE;
	// Stop needs the key and no abnormal port state
	assign go_stop = op_valid && op_code == PDR_OP_STOP &&
		stop_q == PDR_STOP_KEY && !abnormal_state;

	// Merge every reset source into one cause; priority pin first
	always_comb begin
		cause_d = PDR_C_NONE;
		if (pin_rise && vdd_above_detect) begin
			cause_d = PDR_C_PIN;
		end else if (vdd_rise && reset_pin_n && lvd_on) begin
			cause_d = PDR_C_LVD;
		end else if (vdd_rise && reset_pin_n && in_stop && !opt && por_seen_q) begin
			cause_d = PDR_C_POR;
		end else if (!opt && sed_edge && (in_stop || abnormal_state)) begin
			cause_d = PDR_C_SED;
		end else if (!opt && in_stop && ext_wake) begin
			cause_d = PDR_C_INT;
		end else if (watchdog_overflow && mode_q != PDR_BACKUP) begin
			cause_d = PDR_C_WDT;
		end
	end
	assign rst_req = cause_d != PDR_C_NONE;
	// Option 1 wakes from stop without a reset
	assign stop_release = in_stop && (rst_req ||
		(opt && (ext_wake || sed_edge)));

	// ----------------------------------------------------------------
	// Edge history
	// ----------------------------------------------------------------
	// Previous input levels for edge detection
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_q <= 1'b1;
			vdd_q <= 1'b1;
			port_q <= 12'hfff;
		end else begin
			pin_q <= reset_pin_n;
			vdd_q <= vdd_above_detect;
			port_q <= port_now;
		end
	end

	// Power-on reset arms only in stop with option 0
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			por_seen_q <= 1'b0;
		end else if (!in_stop || opt) begin
			por_seen_q <= 1'b0;
		end else if (supply_below_fraction) begin
			por_seen_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Reset pulse generator
	// ----------------------------------------------------------------
	// New sources restart the count, so overlaps give one pulse
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rcnt_q <= 5'h00;
		end else if (rst_req) begin
			rcnt_q <= 5'(PDR_STAB_CYC);
		end else if (rcnt_q != 5'h00) begin
			rcnt_q <= rcnt_q - 5'h01;
		end
	end

	// Cause kept for software; power-on reset spoils data
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cause_q <= PDR_C_NONE;
			undef_q <= 1'b0;
		end else if (rst_req) begin
			cause_q <= cause_d;
			undef_q <= cause_d == PDR_C_POR;
		end else if (rcnt_q == 5'h01) begin
			undef_q <= 1'b0;
		end
	end

	// Program counter loaded when stabilisation ends
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pc_load_q <= 1'b0;
			pc_q <= 16'h0000;
		end else if (rcnt_q == 5'h01) begin
			pc_load_q <= 1'b1;
			pc_q <= PDR_RESET_PC;
		end else if (return_from_interrupt && irq_svc_q) begin
			pc_load_q <= 1'b1;
			pc_q <= ret_pc_q;
		end else begin
			pc_load_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Mode machine
	// ----------------------------------------------------------------
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			PDR_RUN: begin
				if (!reset_pin_n || vdd_fall) begin
					mode_d = PDR_BACKUP;
				end else if (go_stop) begin
					mode_d = PDR_STOP;
				end else if (go_idle) begin
					mode_d = PDR_IDLE;
				end
			end
			PDR_IDLE: begin
				if (!reset_pin_n || vdd_fall) begin
					mode_d = PDR_BACKUP;
				end else if (rst_req || idle_wake) begin
					mode_d = PDR_RUN;
				end
			end
			PDR_STOP: begin
				// Detector fall counts only while it is powered
				if (!reset_pin_n || (vdd_fall && lvd_on)) begin
					mode_d = PDR_BACKUP;
				end else if (stop_release) begin
					mode_d = PDR_RUN;
				end
			end
			PDR_BACKUP: begin
				// Interrupts are ignored; only pin or detector reset
				if (cause_d == PDR_C_PIN || cause_d == PDR_C_LVD ||
					cause_d == PDR_C_POR) begin
					mode_d = PDR_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_q <= PDR_RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Resume address captured at idle entry
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ret_pc_q <= 16'h0000;
		end else if (mode_q == PDR_RUN && mode_d == PDR_IDLE) begin
			ret_pc_q <= next_pc;
		end
	end

	// Interrupt service request after an idle wake
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_svc_q <= 1'b0;
		end else if (mode_q == PDR_IDLE && idle_wake && !rst_req) begin
			irq_svc_q <= 1'b1;
		end else if (return_from_interrupt || rst_req) begin
			irq_svc_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// No wait state: data is prepared in the setup cycle
	assign wr_hit = psel && penable && pready_q && pwrite;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= !is_mapped(paddr);
			unique case (paddr)
				PDR_OFS_STOP: prdata_q <= {24'h000000, stop_q};
				PDR_OFS_CLK: prdata_q <= {24'h000000, clkc_q};
				PDR_OFS_IMR: prdata_q <= {21'h000000, imr_q};
				PDR_OFS_STAT: prdata_q <= {25'h0, opt, undef_q,
					cause_q, mode_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Stop control register; any release clears it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stop_q <= PDR_STOP_RST;
		end else if (stop_release || rst_req) begin
			stop_q <= PDR_STOP_RST;
		end else if (wr_hit && paddr == PDR_OFS_STOP) begin
			stop_q <= pwdata[7:0];
		end
	end

	// Clock control; reset forces divide 1/16, interrupts keep it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			clkc_q <= PDR_CLK_RST;
		end else if (rst_req) begin
			clkc_q <= PDR_CLK_RST;
		end else if (wr_hit && paddr == PDR_OFS_CLK) begin
			clkc_q <= pwdata[7:0];
		end
	end

	// Interrupt mask; all masked leaves reset as the only exit from idle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			imr_q <= PDR_IMR_RST;
		end else if (rst_req) begin
			imr_q <= PDR_IMR_RST;
		end else if (wr_hit && paddr == PDR_OFS_IMR) begin
			imr_q <= pwdata[10:0];
		end
	end

	// ----------------------------------------------------------------
	// Clock gating and registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			osc_run <= 1'b1;
			core_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			active_clk_en <= 1'b1;
			port_dir_hold <= 1'b0;
		end else begin
			// Oscillator stops in stop and backup
			osc_run <= mode_d == PDR_RUN || mode_d == PDR_IDLE;
			core_clk_en <= mode_d == PDR_RUN;
			periph_clk_en <= mode_d == PDR_RUN;
			// Interrupts, timers, counter and comparator run in idle
			active_clk_en <= mode_d == PDR_RUN || mode_d == PDR_IDLE;
			port_dir_hold <= mode_d == PDR_IDLE;
		end
	end

	// Reset outputs follow the pulse counter
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sys_reset <= 1'b1;
			ctrl_regs_reset <= 1'b1;
			data_undefined <= 1'b0;
		end else begin
			sys_reset <= rst_req || rcnt_q > 5'h01;
			ctrl_regs_reset <= rst_req || rcnt_q > 5'h01;
			// Drops with the reset pulse, not a cycle after it
			data_undefined <= (undef_q && rcnt_q > 5'h01) || cause_d == PDR_C_POR;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign clk_div_sel = clkc_q[PDR_DIV_LSB+1:PDR_DIV_LSB];
	assign irq_service = irq_svc_q;
	assign pc_load = pc_load_q;
	assign pc_value = pc_q;
endmodule // pdr_ctrl

// ### hdl/pdr_pkg.sv
// Function
// - Option 0: wake-port falling edge resets
// - Option 1: detector rise resets in stop
// - Option 0: power-on reset acts in stop
// - Reset pin rise resets if supply good
// - Option taken from option byte bit 7
// - Idle opcode halts core and peripheral clocks
// - Idle keeps timers, interrupts, comparator clocked
// - Port directions frozen during idle
// - Reset leaves idle, selects divide 1/16
// - Enabled interrupt leaves idle, divider kept
// - Resume after idle instruction on return
// - Stop woken by pin interrupts only
// - Pin low or supply fall enters backup
// - Backup ends only by pin/detector reset
// - No watchdog reset during backup
// - Stop needs control register 0A5H first
// - Stop release clears stop control register
// - Listed sources all release stop
// - Pin release: controls default, fetch reset address
// - Power-on reset armed only option 0 stop
// - Program counter loaded with 0100H
// - Interrupt in stop: reset only option 0
//
package pdr_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] PDR_OFS_STOP = 8'h00; // stop_control_reg
	localparam logic [7:0] PDR_OFS_CLK = 8'h04; // clock_control_reg
	localparam logic [7:0] PDR_OFS_IMR = 8'h08; // interrupt_mask_reg
	localparam logic [7:0] PDR_OFS_STAT = 8'h0c; // status, read only
	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int PDR_DIV_LSB = 3; // Divider select bits 4:3
	localparam logic [7:0] PDR_STOP_KEY = 8'ha5; // Arms stop
	localparam logic [7:0] PDR_STOP_RST = 8'h00;
	localparam logic [7:0] PDR_CLK_RST = 8'h00; // Divide 1/16
	localparam logic [10:0] PDR_IMR_RST = 11'h000;
	localparam int PDR_OPT_BIT = 7; // Option byte bit
	localparam logic [15:0] PDR_OPT_ADDR = 16'h003f;
	localparam logic [15:0] PDR_RESET_PC = 16'h0100;
	// ----------------------------------------------------------------
	// Opcodes and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] PDR_OP_IDLE = 8'h6f;
	localparam logic [7:0] PDR_OP_STOP = 8'h7f;
	localparam int PDR_STAB_OSC = 16; // Oscillator clocks
	localparam int PDR_STAB_CYC = PDR_STAB_OSC;
	// ----------------------------------------------------------------
	// Power modes, Gray coded along run-idle-stop-backup
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PDR_RUN = 2'b00,
		PDR_IDLE = 2'b01,
		PDR_STOP = 2'b11,
		PDR_BACKUP = 2'b10
	} pdr_mode_t;
	// Reset cause codes shown in status
	localparam logic [2:0] PDR_C_NONE = 3'h0;
	localparam logic [2:0] PDR_C_PIN = 3'h1;
	localparam logic [2:0] PDR_C_LVD = 3'h2;
	localparam logic [2:0] PDR_C_POR = 3'h3;
	localparam logic [2:0] PDR_C_INT = 3'h4;
	localparam logic [2:0] PDR_C_SED = 3'h5;
	localparam logic [2:0] PDR_C_WDT = 3'h6;
endpackage

// ### testbench/pdr_ctrl_checker.sv
module pdr_ctrl_checker import pdr_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic op_valid,
	input wire logic [7:0] op_code,
	input wire logic [7:0] option_byte,
	input wire logic reset_pin_n,
	input wire logic vdd_above_detect,
	input wire logic abnormal_state,
	input wire logic internal_irq,
	input wire logic [7:0] wake_port_zero,
	input wire logic [3:0] wake_port_two_upper,
	input wire logic sys_reset,
	input wire logic ctrl_regs_reset,
	input wire logic osc_run,
	input wire logic core_clk_en,
	input wire logic periph_clk_en,
	input wire logic active_clk_en,
	input wire logic port_dir_hold,
	input wire logic [1:0] clk_div_sel,
	input wire logic irq_service,
	input wire logic pc_load,
	input wire logic [15:0] pc_value
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ----------------
	// Helper state
	// ----------------
	logic key_q; // Stop key written since last stop request
	logic [5:0] hi_q; // Reset length so far, saturating
	logic [11:0] prt_q; // Last sample of the wake pins
	logic fall_w; // Some wake pin fell
	assign fall_w = |(prt_q & ~{wake_port_zero, wake_port_two_upper});
	// Pin history and reset length; the short pulse after rst is skipped below
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prt_q <= 12'hfff;
			hi_q <= 6'h00;
		end else begin
			prt_q <= {wake_port_zero, wake_port_two_upper};
			hi_q <= sys_reset ? hi_q + {5'h00, hi_q != 6'h3f} : 6'h00;
		end
	end
	// Any stop request or reset consumes the key, as the register is cleared
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			key_q <= 1'h0;
		else if (sys_reset || op_valid && op_code == PDR_OP_STOP)
			key_q <= 1'h0;
		else if (psel && penable && pready && pwrite && paddr == PDR_OFS_STOP)
			key_q <= pwdata[7:0] == PDR_STOP_KEY;
	end
	// ----------------
	// Properties
	// ----------------
	a_stop_entry: assert property (
		op_valid && op_code == PDR_OP_STOP && core_clk_en && !abnormal_state && reset_pin_n
		&& vdd_above_detect && !sys_reset |-> ##2 osc_run == !$past(key_q, 2)
	) else $error("stop entry wrong");
	a_idle_gate: assert property (
		op_valid && op_code == PDR_OP_IDLE && core_clk_en && !internal_irq && !sys_reset
		|-> ##2 !core_clk_en && !periph_clk_en && active_clk_en && port_dir_hold
	) else $error("idle gating wrong");
	a_backup_entry: assert property (
		!reset_pin_n [*3] |-> !osc_run
	) else $error("backup not entered");
	a_pin_reset: assert property (
		$rose(reset_pin_n) && vdd_above_detect && $past(vdd_above_detect) |-> ##[1:2] sys_reset
	) else $error("pin rise gave no reset");
	a_reset_width: assert property (
		$fell(sys_reset) && hi_q > 6'h02 |-> hi_q >= PDR_STAB_CYC
	) else $error("reset pulse short");
	a_pc_reload: assert property (
		$fell(sys_reset) && hi_q > 6'h02 |-> ##[0:1] pc_load && pc_value == PDR_RESET_PC
	) else $error("no reset address load");
	a_ctrl_reset: assert property (
		ctrl_regs_reset == sys_reset
	) else $error("control reset split");
	a_irq_div: assert property (
		$rose(irq_service) |-> $stable(clk_div_sel) && !sys_reset
	) else $error("idle wake changed divider");
	a_port_reset: assert property (
		!osc_run && !option_byte[PDR_OPT_BIT] && reset_pin_n && vdd_above_detect && fall_w
		|-> ##[1:2] sys_reset
	) else $error("port edge gave no reset");
	a_port_wake: assert property (
		!osc_run && option_byte[PDR_OPT_BIT] && reset_pin_n && vdd_above_detect && fall_w
		&& !sys_reset |-> ##1 !sys_reset [*2]
	) else $error("port wake reset");
endmodule // pdr_ctrl_checker

bind pdr_ctrl pdr_ctrl_checker pdr_ctrl_checker_inst (.mclk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .op_valid, .op_code, .option_byte, .reset_pin_n,
	.vdd_above_detect, .abnormal_state, .internal_irq, .wake_port_zero, .wake_port_two_upper,
	.sys_reset, .ctrl_regs_reset, .osc_run, .core_clk_en, .periph_clk_en, .active_clk_en,
	.port_dir_hold, .clk_div_sel, .irq_service, .pc_load, .pc_value);

// ### testbench/pdr_core_model.sv
module pdr_core_model import pdr_pkg::*; (
	input wire logic mclk,
	input wire logic rst,
	input wire logic go, // Execute op next cycle
	input wire logic [7:0] op,
	input wire logic [3:0] svc_wait, // Handler length, below 15
	input wire logic irq_service,
	output logic op_valid,
	output logic [7:0] op_code,
	output logic [15:0] next_pc,
	output logic return_from_interrupt
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] svc_q; // Handler cycles so far
	// Opcode pulse; code bus toggles between ops so a stale value recurs only every other cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			op_valid <= 1'h0;
			op_code <= 8'h00;
			next_pc <= 16'h0000;
		end else begin
			op_valid <= go;
			op_code <= go ? op : ~op_code;
			next_pc <= go ? 16'h0201 : ~next_pc;
		end
	end
	// Handler runs svc_wait cycles, then returns once
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			svc_q <= 4'h0;
			return_from_interrupt <= 1'h0;
		end else begin
			return_from_interrupt <= 1'h0;
			if (!irq_service)
				svc_q <= 4'h0;
			else if (svc_q <= svc_wait) begin
				svc_q <= svc_q + 4'h1;
				return_from_interrupt <= svc_q == svc_wait;
			end
		end
	end
endmodule // pdr_core_model

// ### testbench/tb_top.sv
module tb_top import pdr_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, op_go = 1'h0;
	logic internal_irq = 1'h0, reset_pin_n = 1'h1, vdd_above_detect = 1'h1;
	logic supply_below_fraction = 1'h0, watchdog_overflow = 1'h0, abnormal_state = 1'h0;
	logic [7:0] paddr = 8'h00, op_sel = 8'h00, option_byte = 8'h80, wake_port_zero = 8'hff;
	logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h05f8;
	logic [9:0] external_interrupt_lines = 10'h000;
	logic [3:0] wake_port_two_upper = 4'hf, svc_wait = 4'h2;
	logic pready, pslverr, op_valid, return_from_interrupt, sys_reset, ctrl_regs_reset;
	logic data_undefined, osc_run, core_clk_en, periph_clk_en, active_clk_en, port_dir_hold;
	logic irq_service, pc_load;
	logic [7:0] op_code;
	logic [15:0] next_pc, pc_value;
	logic [1:0] clk_div_sel;
	logic [32:0] q[$]; // Expected {pslverr, prdata} per read
	int bad_count = 0, samples_checked = 0;
	always #2.5 mclk = ~mclk;
	pdr_ctrl #(.N_EXT(10)) pdr_ctrl_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .op_valid, .op_code, .next_pc,
		.return_from_interrupt, .option_byte, .reset_pin_n, .vdd_above_detect,
		.supply_below_fraction, .watchdog_overflow, .abnormal_state, .external_interrupt_lines,
		.internal_irq, .wake_port_zero, .wake_port_two_upper, .sys_reset, .ctrl_regs_reset,
		.data_undefined, .osc_run, .core_clk_en, .periph_clk_en, .active_clk_en,
		.port_dir_hold, .clk_div_sel, .irq_service, .pc_load, .pc_value);
	pdr_core_model pdr_core_model_inst (.mclk, .rst, .go(op_go), .op(op_sel), .svc_wait,
		.irq_service, .op_valid, .op_code, .next_pc, .return_from_interrupt);
	// ----------------
	// Helpers
	// ----------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [32:0] g, input logic [32:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Bounded wait; running out ends the run as a failure
	task automatic wt(ref logic s, input logic v);
		for (int n = 0; n < 400; n++) begin
			if (s === v)
				return;
			@(negedge mclk);
		end
		bad_count++;
		print_verdict();
	endtask
	// APB transfer: request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		@(negedge mclk);
		wt(pready, 1'h1);
		@(posedge mclk);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [32:0] e);
		q.push_back(e);
		apb(1'h0, a, 32'h0);
	endtask
	task op(input logic [7:0] c);
		@(posedge mclk);
		op_go <= 1'h1;
		op_sel <= c;
		@(posedge mclk);
		op_go <= 1'h0;
		repeat (3) @(negedge mclk);
	endtask
	// Read results are taken at the completing edge, against the oldest note
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'h1 && !pwrite)
			chk({pslverr, prdata}, q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		print_verdict();
	end
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'h0;
		rd(PDR_OFS_STOP, {25'h0, PDR_STOP_RST});
		rd(PDR_OFS_CLK, {25'h0, PDR_CLK_RST});
		rd(PDR_OFS_IMR, {22'h0, PDR_IMR_RST});
		r = xs();
		apb(1'h1, PDR_OFS_CLK, {24'h0, r[7:0]});
		rd(PDR_OFS_CLK, {25'h0, r[7:0]});
		chk(clk_div_sel, r[4:3]);
		rd(8'h10, {1'h1, 32'h0});
		apb(1'h1, PDR_OFS_IMR, {21'h0, 1'h1, r[9:0]});
		$display("done registers");
		svc_wait <= {1'h0, r[12:10]} + 4'h1;
		op(PDR_OP_IDLE);
		chk({core_clk_en, periph_clk_en, active_clk_en, port_dir_hold}, 4'h3);
		@(posedge mclk) internal_irq <= 1'h1;
		wt(irq_service, 1'h1);
		chk(clk_div_sel, r[4:3]);
		@(posedge mclk) internal_irq <= 1'h0;
		wt(irq_service, 1'h0);
		chk(core_clk_en, 1'h1);
		chk(pc_value, 16'h0201);
		$display("done idle");
		op(PDR_OP_STOP);
		chk(osc_run, 1'h1);
		apb(1'h1, PDR_OFS_STOP, {24'h0, PDR_STOP_KEY});
		op(PDR_OP_STOP);
		chk(osc_run, 1'h0);
		// Enabled internal interrupt must not wake stop
		@(posedge mclk) internal_irq <= 1'h1;
		repeat (3) @(negedge mclk);
		chk(osc_run, 1'h0);
		r = xs();
		@(posedge mclk) wake_port_zero <= ~(8'h01 << r[2:0]);
		internal_irq <= 1'h0;
		wt(osc_run, 1'h1);
		chk(sys_reset, 1'h0);
		rd(PDR_OFS_STOP, 33'h0);
		@(posedge mclk) wake_port_zero <= 8'hff;
		option_byte <= 8'h00;
		apb(1'h1, PDR_OFS_STOP, {24'h0, PDR_STOP_KEY});
		op(PDR_OP_STOP);
		@(posedge mclk) wake_port_two_upper <= 4'h7;
		wt(sys_reset, 1'h1);
		wt(sys_reset, 1'h0);
		wt(pc_load, 1'h1);
		chk(pc_value, PDR_RESET_PC);
		rd(PDR_OFS_CLK, {25'h0, PDR_CLK_RST});
		// Option 0: supply dips below the fraction in stop, then recovers
		apb(1'h1, PDR_OFS_STOP, {24'h0, PDR_STOP_KEY});
		op(PDR_OP_STOP);
		@(posedge mclk) supply_below_fraction <= 1'h1;
		vdd_above_detect <= 1'h0;
		repeat (3) @(negedge mclk);
		chk({osc_run, sys_reset}, 2'h0);
		@(posedge mclk) supply_below_fraction <= 1'h0;
		vdd_above_detect <= 1'h1;
		wt(data_undefined, 1'h1);
		chk(sys_reset, 1'h1);
		wt(sys_reset, 1'h0);
		chk(data_undefined, 1'h0);
		$display("done stop");
		@(posedge mclk) wake_port_two_upper <= 4'hf;
		option_byte <= 8'h80;
		reset_pin_n <= 1'h0;
		repeat (3) @(negedge mclk);
		chk(osc_run, 1'h0);
		@(posedge mclk) watchdog_overflow <= 1'h1;
		@(posedge mclk) watchdog_overflow <= 1'h0;
		vdd_above_detect <= 1'h0;
		repeat (4) @(negedge mclk);
		chk(sys_reset, 1'h0);
		@(posedge mclk) reset_pin_n <= 1'h1;
		repeat (4) @(negedge mclk);
		chk({sys_reset, osc_run}, 2'h0);
		@(posedge mclk) vdd_above_detect <= 1'h1;
		wt(sys_reset, 1'h1);
		wt(sys_reset, 1'h0);
		@(posedge mclk) reset_pin_n <= 1'h0;
		repeat (3) @(posedge mclk);
		reset_pin_n <= 1'h1;
		wt(sys_reset, 1'h1);
		wt(sys_reset, 1'h0);
		wt(pc_load, 1'h1);
		$display("done backup");
		print_verdict();
	end
endmodule // tb_top
